// ===== logic/dbsr_top.sv
// serial register port with bias set-points and six protection flags
`timescale 1ns/100ps
module dbsr_top
   import dbsr_pkg::*;
(
   input  wire logic            clk,
   input  wire logic            rst,
   input  wire logic            swReset,
   input  wire logic            scl,
   input  wire logic            sdaIn,
   output logic                 sdaOut,
   output logic                 sdaOe,
   input  wire dbsr_faults_type faultIn,
   output dbsr_levels_type      levels,
   output logic [7:0]           flagsByte
);

   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   typedef struct packed {
      logic            sclMeta;
      logic            sclSync;
      logic            sclPrev;
      logic            sdaMeta;
      logic            sdaSync;
      logic            sdaPrev;
      logic [5:0]      faultMeta;
      logic [5:0]      faultSync;
      dbsr_state_type  state;
      logic [3:0]      bitCnt;
      logic [7:0]      shift;
      logic [7:0]      ptr;
      logic            readMode;
      logic            ackPhase;
      logic            sdaDrive;
      logic [5:0]      boost;
      logic [5:0]      pos;
      logic [5:0]      neg;
      logic [5:0]      flags;
   } dbsr_regs_type;

   localparam dbsr_regs_type REGS_RST = '{
      sclMeta: 1'b1, sclSync: 1'b1, sclPrev: 1'b1,
      sdaMeta: 1'b1, sdaSync: 1'b1, sdaPrev: 1'b1,
      faultMeta: 6'h00, faultSync: 6'h00, state: ST_IDLE,
      bitCnt: 4'h0, shift: 8'h00, ptr: 8'h00, readMode: 1'b0,
      ackPhase: 1'b0, sdaDrive: 1'b0, boost: BOOST_RST, pos: POS_RST,
      neg: NEG_RST, flags: FLAGS_RST};

   dbsr_regs_type cur_reg;
   dbsr_regs_type cur_next;
   logic          sclRise;
   logic          sclFall;
   logic          startCond;
   logic          stopCond;
   logic          wrEn;
   logic [7:0]    wrData;
   logic [5:0]    clrFlags;
   logic [7:0]    nextPtr;

   // reserved bits and unmapped addresses read as zero
   function automatic logic [7:0] read_byte(input logic [7:0] a,
                                            input dbsr_regs_type r);
      logic [7:0] d;
      d = 8'h00;
      unique case (a)
         BOOST_ADDR: d = {2'b00, r.boost};
         POS_ADDR:   d = {2'b00, r.pos};
         NEG_ADDR:   d = {2'b00, r.neg};
         FLAGS_ADDR: d = {2'b00, r.flags};
         default:    d = 8'h00;
      endcase
      return d;
   endfunction

   assign sclRise   = cur_reg.sclSync & ~cur_reg.sclPrev;
   assign sclFall   = ~cur_reg.sclSync & cur_reg.sclPrev;
   assign startCond = cur_reg.sclSync & cur_reg.sclPrev &
                      cur_reg.sdaPrev & ~cur_reg.sdaSync;
   assign stopCond  = cur_reg.sclSync & cur_reg.sclPrev &
                      ~cur_reg.sdaPrev & cur_reg.sdaSync;
   assign nextPtr   = cur_reg.ptr + 8'h01;

   // -----------------------------------------------------------------
   // next state
   // -----------------------------------------------------------------
   always_comb begin
      cur_next = cur_reg;
      wrEn     = 1'b0;
      wrData   = {cur_reg.shift[6:0], cur_reg.sdaSync};
      clrFlags = 6'h00;
      cur_next.sclMeta   = scl;
      cur_next.sclSync   = cur_reg.sclMeta;
      cur_next.sclPrev   = cur_reg.sclSync;
      cur_next.sdaMeta   = sdaIn;
      cur_next.sdaSync   = cur_reg.sdaMeta;
      cur_next.sdaPrev   = cur_reg.sdaSync;
      cur_next.faultMeta = faultIn;
      cur_next.faultSync = cur_reg.faultMeta; // R04 R05 R06 R07 R08 R09

      unique case (cur_reg.state)
         ST_IDLE: begin
         end
         ST_ADDR, ST_REG, ST_WR: begin
            if (sclRise) begin
               cur_next.shift  = wrData;
               cur_next.bitCnt = cur_reg.bitCnt + 4'h1;
               if (cur_reg.bitCnt == 4'h7) begin
                  if (cur_reg.state == ST_ADDR) begin
                     if (cur_reg.shift[6:0] == DEV_ADDR) begin
                        cur_next.readMode = cur_reg.sdaSync;
                        cur_next.state    = ST_ADDR_ACK;
                     end else begin
                        cur_next.state = ST_IDLE;
                     end
                  end else if (cur_reg.state == ST_REG) begin
                     cur_next.ptr   = wrData;
                     cur_next.state = ST_REG_ACK;
                  end else begin
                     wrEn           = 1'b1;
                     cur_next.ptr   = nextPtr;
                     cur_next.state = ST_WR_ACK;
                  end
               end
            end
         end
         ST_ADDR_ACK, ST_REG_ACK, ST_WR_ACK: begin
            if (sclFall) begin
               cur_next.ackPhase = ~cur_reg.ackPhase;
               cur_next.sdaDrive = ~cur_reg.ackPhase;
               cur_next.bitCnt   = 4'h0;
               if (cur_reg.ackPhase) begin
                  if (cur_reg.state != ST_ADDR_ACK) begin
                     cur_next.state = ST_WR;
                  end else if (cur_reg.readMode) begin
                     cur_next.shift    = read_byte(cur_reg.ptr, cur_reg);
                     cur_next.sdaDrive = ~cur_next.shift[7];
                     cur_next.state    = ST_RD;
                     if (cur_reg.ptr == FLAGS_ADDR) begin
                        clrFlags = cur_reg.flags; // R12
                     end
                  end else begin
                     cur_next.state = ST_REG;
                  end
               end
            end
         end
         ST_RD: begin
            if (sclRise) begin
               cur_next.bitCnt = cur_reg.bitCnt + 4'h1;
            end
            if (sclFall) begin
               if (cur_reg.bitCnt == 4'h8) begin
                  cur_next.sdaDrive = 1'b0;
                  cur_next.state    = ST_RD_ACK;
               end else begin
                  cur_next.shift    = {cur_reg.shift[6:0], 1'b0};
                  cur_next.sdaDrive = ~cur_reg.shift[6];
               end
            end
         end
         ST_RD_ACK: begin
            if (sclRise) begin
               cur_next.ackPhase = ~cur_reg.sdaSync;
            end
            if (sclFall) begin
               cur_next.ackPhase = 1'b0;
               cur_next.bitCnt   = 4'h0;
               if (cur_reg.ackPhase) begin
                  cur_next.ptr      = nextPtr;
                  cur_next.shift    = read_byte(nextPtr, cur_reg);
                  cur_next.sdaDrive = ~cur_next.shift[7];
                  cur_next.state    = ST_RD;
                  if (nextPtr == FLAGS_ADDR) begin
                     clrFlags = cur_reg.flags; // R12
                  end
               end else begin
                  cur_next.state = ST_IDLE;
               end
            end
         end
         default: begin
            cur_next.state    = ST_IDLE;
            cur_next.sdaDrive = 1'b0;
         end
      endcase

      if (startCond) begin
         cur_next.state    = ST_ADDR;
         cur_next.bitCnt   = 4'h0;
         cur_next.ackPhase = 1'b0;
         cur_next.sdaDrive = 1'b0;
      end else if (stopCond) begin
         cur_next.state    = ST_IDLE;
         cur_next.ackPhase = 1'b0;
         cur_next.sdaDrive = 1'b0;
      end

      // each set-point moves only on a write to its own address or on swReset
      if (wrEn) begin
         unique case (cur_reg.ptr)
            BOOST_ADDR: cur_next.boost = wrData[5:0]; // R01 R11
            POS_ADDR:   cur_next.pos   = wrData[5:0]; // R02 R11
            NEG_ADDR:   cur_next.neg   = wrData[5:0]; // R03 R11
            default: begin
            end
         endcase
      end

      // sticky flags: a live fault wins over the read clear
      cur_next.flags = (cur_reg.flags & ~clrFlags) | cur_reg.faultSync; // R12

      if (swReset) begin
         cur_next.boost    = BOOST_RST;
         cur_next.pos      = POS_RST;
         cur_next.neg      = NEG_RST;
         cur_next.flags    = FLAGS_RST;
         cur_next.ptr      = 8'h00;
         cur_next.state    = ST_IDLE;
         cur_next.sdaDrive = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cur_reg <= REGS_RST;
      end else begin
         cur_reg <= cur_next;
      end
   end

   // -----------------------------------------------------------------
   // outputs
   // -----------------------------------------------------------------
   assign sdaOut = 1'b0;
   assign sdaOe  = cur_reg.sdaDrive;
   assign levels = '{biasBoostLevel: cur_reg.boost,
                     positiveBiasLevel: cur_reg.pos,
                     negativeBiasLevel: cur_reg.neg};
   assign flagsByte = {2'b00, cur_reg.flags}; // R10

   // -----------------------------------------------------------------
   // assertions
   // -----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_fault(int b);
      cur_reg.faultSync[b] && !swReset;
   endsequence

   sequence s_flag_read;
      clrFlags != 6'h00 && cur_reg.faultSync == 6'h00 && !swReset;
   endsequence

   property p_boost_reset;
      @(posedge clk) disable iff (1'b0)
      rst |=> levels.biasBoostLevel == BOOST_RST;
   endproperty
   a_boost_reset: assert property (p_boost_reset) // R01
      else $error("bias boost level wrong after reset");

   property p_pos_reset;
      @(posedge clk) disable iff (1'b0)
      rst |=> levels.positiveBiasLevel == POS_RST;
   endproperty
   a_pos_reset: assert property (p_pos_reset) // R02
      else $error("positive bias level wrong after reset");

   property p_neg_reset;
      @(posedge clk) disable iff (1'b0)
      rst |=> levels.negativeBiasLevel == NEG_RST;
   endproperty
   a_neg_reset: assert property (p_neg_reset) // R03
      else $error("negative bias level wrong after reset");

   property p_boost_ov;
      s_fault(BOOST_OV_BIT) |=> flagsByte[BOOST_OV_BIT];
   endproperty
   a_boost_ov: assert property (p_boost_ov) // R04
      else $error("bias boost overvoltage not flagged");

   property p_neg_ov;
      s_fault(NEG_OV_BIT) |=> flagsByte[NEG_OV_BIT];
   endproperty
   a_neg_ov: assert property (p_neg_ov) // R05
      else $error("negative bias overvoltage not flagged");

   property p_pos_sc;
      s_fault(POS_SC_BIT) |=> flagsByte[POS_SC_BIT];
   endproperty
   a_pos_sc: assert property (p_pos_sc) // R06
      else $error("positive bias short not flagged");

   property p_neg_sc;
      s_fault(NEG_SC_BIT) |=> flagsByte[NEG_SC_BIT];
   endproperty
   a_neg_sc: assert property (p_neg_sc) // R07
      else $error("negative bias short not flagged");

   property p_flash_oc;
      s_fault(FLASH_OC_BIT) |=> flagsByte[FLASH_OC_BIT];
   endproperty
   a_flash_oc: assert property (p_flash_oc) // R08
      else $error("flash overcurrent not flagged");

   property p_bl_oc;
      s_fault(BL_OC_BIT) |=> flagsByte[BL_OC_BIT];
   endproperty
   a_bl_oc: assert property (p_bl_oc) // R09
      else $error("backlight overcurrent not flagged");

   property p_flags_reset;
      @(posedge clk) disable iff (1'b0)
      rst |=> flagsByte == {2'b00, FLAGS_RST} ##1 flagsByte[7:6] == 2'b00;
   endproperty
   a_flags_reset: assert property (p_flags_reset) // R10
      else $error("flag register not clear after reset");

   property p_boost_own_write;
      !(wrEn && cur_reg.ptr == BOOST_ADDR) && !swReset
         |=> $stable(levels.biasBoostLevel);
   endproperty
   a_boost_own_write: assert property (p_boost_own_write) // R11
      else $error("bias boost level moved without its own write");

   property p_flag_hold;
      clrFlags == 6'h00 && !swReset
         |=> (cur_reg.flags & $past(cur_reg.flags)) == $past(cur_reg.flags);
   endproperty
   a_flag_hold: assert property (p_flag_hold) // R12
      else $error("flag dropped without a read");

   property p_flag_clear;
      s_flag_read |=> cur_reg.flags == 6'h00;
   endproperty
   a_flag_clear: assert property (p_flag_clear) // R12
      else $error("flag not cleared by read");

endmodule

// ===== logic/dbsr_pkg.sv
// constants, types and register map of the display bias setting registers
// Notes on behaviour
// R01: bias boost level in bits 5:0, 4.5 V plus 50 mV per code, reset 011110.
// R02: positive bias level in bits 5:0, 4 V plus 50 mV per code, reset 011110.
// R03: negative bias level in bits 5:0, -4 V less 50 mV per code, reset 011100.
// R04: flag bit 5 is set when the bias boost sees overvoltage.
// R05: flag bit 4 is set when the negative bias output sees overvoltage.
// R06: flag bit 3 is set when the positive bias output is shorted.
// R07: flag bit 2 is set when the negative bias output is shorted.
// R08: flag bit 1 is set when the flash boost trips overcurrent.
// R09: flag bit 0 is set when the backlight boost trips overcurrent.
// R10: flag register at 0x10 resets to zero; bits 7 and 6 are reserved.
// R11: each function's setting changes only through its own register.
// R12: a flag stays set until the host reads it, then clears unless still faulty.
package dbsr_pkg;

   // -----------------------------------------------------------------
   // register map
   // -----------------------------------------------------------------
   localparam logic [7:0] BOOST_ADDR = 8'h0d;
   localparam logic [7:0] POS_ADDR   = 8'h0e;
   localparam logic [7:0] NEG_ADDR   = 8'h0f;
   localparam logic [7:0] FLAGS_ADDR = 8'h10;

   localparam logic [5:0] BOOST_RST  = 6'h1e;
   localparam logic [5:0] POS_RST    = 6'h1e;
   localparam logic [5:0] NEG_RST    = 6'h1c;
   localparam logic [5:0] FLAGS_RST  = 6'h00;

   // flag bit positions
   localparam int BOOST_OV_BIT = 5;
   localparam int NEG_OV_BIT   = 4;
   localparam int POS_SC_BIT   = 3;
   localparam int NEG_SC_BIT   = 2;
   localparam int FLASH_OC_BIT = 1;
   localparam int BL_OC_BIT    = 0;

   // serial port slave address, value arbitrary
   localparam logic [6:0] DEV_ADDR = 7'h2a;

   // -----------------------------------------------------------------
   // types
   // -----------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_IDLE     = 4'h0,
      ST_ADDR     = 4'h1,
      ST_ADDR_ACK = 4'h3,
      ST_REG      = 4'h2,
      ST_REG_ACK  = 4'h6,
      ST_WR       = 4'h7,
      ST_WR_ACK   = 4'h5,
      ST_RD       = 4'h4,
      ST_RD_ACK   = 4'hc
   } dbsr_state_type;

   typedef struct packed {
      logic biasBoostOvervoltageFlag;
      logic negativeBiasOvervoltageFlag;
      logic positiveBiasShortFlag;
      logic negativeBiasShortFlag;
      logic flashBoostOvercurrentFlag;
      logic backlightBoostOvercurrentFlag;
   } dbsr_faults_type;

   typedef struct packed {
      logic [5:0] biasBoostLevel;
      logic [5:0] positiveBiasLevel;
      logic [5:0] negativeBiasLevel;
   } dbsr_levels_type;

endpackage

// ===== tb/dbsr_host.sv
// serial register host model for the bias setting register port
`timescale 1ns/100ps
module dbsr_host
   import dbsr_pkg::*;
(
   input  wire logic clk,
   input  wire logic sdaLine,
   output logic      scl,
   output logic      pullLow
);
   initial begin
      scl = 1'b1;
      pullLow = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   // data moves only while scl is low; each phase lasts at least 4 clocks
   task automatic bit_io(input logic b, output logic s);
      pullLow <= ~b;
      tick(4);
      scl <= 1'b1;
      tick(6);
      s = sdaLine;
      scl <= 1'b0;
      tick(4);
   endtask

   task automatic start();
      pullLow <= 1'b0;
      tick(4);
      scl <= 1'b1;
      tick(6);
      pullLow <= 1'b1;
      tick(6);
      scl <= 1'b0;
      tick(4);
   endtask

   task automatic stop();
      pullLow <= 1'b1;
      tick(4);
      scl <= 1'b1;
      tick(6);
      pullLow <= 1'b0;
      tick(6);
   endtask

   task automatic byte_io(input logic [7:0] tx, input logic hostAck,
                          output logic [7:0] rx, output logic acked);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(tx[i], s);
         rx[i] = s;
      end
      bit_io(~hostAck, s);
      acked = ~s;
   endtask

   task automatic write_reg(input logic [7:0] ptr, input logic [7:0] d,
                            input logic [6:0] dev, output logic ok);
      logic [7:0] rx;
      logic       a0;
      logic       a1;
      logic       a2;
      start();
      byte_io({dev, 1'b0}, 1'b0, rx, a0);
      byte_io(ptr, 1'b0, rx, a1);
      byte_io(d, 1'b0, rx, a2);
      stop();
      ok = a0 & a1 & a2;
   endtask

   // last data byte is answered with a release, ending the read
   task automatic read_reg(input logic [7:0] ptr, output logic [7:0] d,
                           output logic ok);
      logic [7:0] rx;
      logic       a0;
      logic       a1;
      logic       a2;
      logic       a3;
      start();
      byte_io({DEV_ADDR, 1'b0}, 1'b0, rx, a0);
      byte_io(ptr, 1'b0, rx, a1);
      start();
      byte_io({DEV_ADDR, 1'b1}, 1'b0, rx, a2);
      byte_io(8'hff, 1'b0, d, a3);
      stop();
      // the device must have let go of the line in the host's ack slot
      ok = a0 & a1 & a2 & ~a3;
   endtask
endmodule

// ===== tb/testbench.sv
// self-checking bench for the bias setting register port
`timescale 1ns/100ps
module testbench
   import dbsr_pkg::*;
;
   logic            clk;
   logic            rst;
   logic            swReset;
   logic            sdaOut;
   logic            sdaOe;
   logic            scl;
   logic            pullLow;
   logic            sdaLine;
   dbsr_faults_type faultIn;
   dbsr_levels_type levels;
   logic [7:0]      flagsByte;
   int              nMismatch;
   int              totalChecks;
   int              seed;
   logic [5:0]      mirror [3];
   logic [7:0]      rd;
   logic [7:0]      a;
   logic [7:0]      d;
   logic            ok;

   // open drain line with pull-up
   assign sdaLine = ~pullLow & ~(sdaOe & ~sdaOut);

   dbsr_top DUT (.clk(clk), .rst(rst), .swReset(swReset), .scl(scl),
      .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe), .faultIn(faultIn),
      .levels(levels), .flagsByte(flagsByte));

   dbsr_host host (.clk(clk), .sdaLine(sdaLine), .scl(scl),
      .pullLow(pullLow));

   function automatic logic [17:0] exp_levels();
      return {mirror[0], mirror[1], mirror[2]};
   endfunction

   function automatic logic [7:0] reg_view(logic [7:0] ad);
      if (ad >= BOOST_ADDR && ad <= NEG_ADDR)
         return {2'h0, mirror[ad - BOOST_ADDR]};
      return 8'h00;
   endfunction

   task automatic check(input string what, input logic [19:0] exp,
                        input logic [19:0] got);
      totalChecks++;
      if (got !== exp) begin
         nMismatch++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   task automatic give_verdict();
      if (nMismatch == 0 && totalChecks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   initial begin
      repeat (90000) @(posedge clk);
      nMismatch++;
      give_verdict();
   end

   // -----------------------------------------------------------------
   // main sequence
   // -----------------------------------------------------------------
   initial begin
      rst = 1'b1;
      swReset = 1'b0;
      faultIn = '0;
      nMismatch = 0;
      totalChecks = 0;
      seed = 25259;
      mirror = '{BOOST_RST, POS_RST, NEG_RST};
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      check("levels", exp_levels(), levels);
      check("flags", 8'h00, flagsByte);
      for (int i = 0; i < 5; i++) begin
         a = BOOST_ADDR + 8'(i);
         host.read_reg(a, rd, ok);
         check("reset read", {ok, reg_view(a)}, {1'b1, rd});
      end
      // corner codes first, then random ones
      for (int i = 0; i < 9; i++) begin
         a = BOOST_ADDR + 8'(i % 3);
         d = (i < 3) ? 8'hff : (i < 6) ? 8'hc0 : 8'($random(seed));
         host.write_reg(a, d, DEV_ADDR, ok);
         mirror[a - BOOST_ADDR] = d[5:0];
         check("levels", {ok, exp_levels()}, {1'b1, levels});
         host.read_reg(a, rd, ok);
         check("readback", reg_view(a), rd);
      end
      host.write_reg(FLAGS_ADDR, 8'hff, DEV_ADDR, ok);
      host.read_reg(FLAGS_ADDR, rd, ok);
      check("flags after write", 8'h00, rd);
      host.write_reg(BOOST_ADDR, 8'h01, DEV_ADDR ^ 7'h01, ok);
      check("foreign address", {1'b0, exp_levels()}, {ok, levels});
      for (int i = 0; i < 6; i++) begin
         faultIn <= dbsr_faults_type'(6'h01 << i);
         repeat (2) @(posedge clk);
         faultIn <= '0;
         repeat (4) @(posedge clk);
         check("flag latch", 8'h01 << i, flagsByte);
         host.read_reg(FLAGS_ADDR, rd, ok);
         check("flag read", 8'h01 << i, rd);
         check("flag clear", 8'h00, flagsByte);
      end
      d = 8'($random(seed)) & 8'h3f | 8'h01;
      faultIn <= d[5:0];
      repeat (4) @(posedge clk);
      host.read_reg(FLAGS_ADDR, rd, ok);
      check("flag read", d, rd);
      check("fault persists", d, flagsByte);
      faultIn <= '0;
      repeat (4) @(posedge clk);
      host.read_reg(FLAGS_ADDR, rd, ok);
      check("flag reread", d, rd);
      check("flag clear", 8'h00, flagsByte);
      faultIn <= 6'h3f;
      @(posedge clk);
      faultIn <= '0;
      repeat (4) @(posedge clk);
      check("flags before soft reset", 8'h3f, flagsByte);
      swReset <= 1'b1;
      @(posedge clk);
      swReset <= 1'b0;
      repeat (2) @(posedge clk);
      mirror = '{BOOST_RST, POS_RST, NEG_RST};
      check("soft reset", exp_levels(), levels);
      check("soft reset flags", 8'h00, flagsByte);
      give_verdict();
   end
endmodule
